/* File: include/wss_defs.svh */
/*
  constants of the waveform sequence slot block: register indices, field positions,
  reset values and timing figures.
  assumes it is included by bare name from the package and the design files.
*/
`ifndef WSS_DEFS_SVH
`define WSS_DEFS_SVH

// register indices; byte address = 4 x index so each register owns one bus word
`define WSS_IDX_START      8'h0c
`define WSS_IDX_SLOT_FIRST 8'h0f
`define WSS_IDX_SLOT_FIVE  8'h13
`define WSS_IDX_SLOT_SIX   8'h14
`define WSS_IDX_SLOT_LAST  8'h16
`define WSS_IDX_STATUS     8'h17

`define WSS_SLOT_COUNT     8
`define WSS_MODE_BIT       7
`define WSS_PAYLOAD_MSB    6
`define WSS_SLOT_RESET     8'h00
`define WSS_START_BIT      0
`define WSS_STAT_BUSY_BIT  0
`define WSS_STAT_POS_LSB   1

// delay step in microseconds and the clock period in picoseconds
`define WSS_STEP_US        10000
`define WSS_CLK_PS         5000
// step in ns over period in ns; kept in ns so the product stays inside 32 bits
`define WSS_STEP_CYCLES    ((`WSS_STEP_US * 1000) / (`WSS_CLK_PS / 1000))

`endif

/* File: include/wss_pkg.sv */
/*
  types of the waveform sequence slot block.
  assumes wss_defs.svh is reachable on the include path.
*/
package wss_pkg;
  `include "wss_defs.svh"

  typedef struct packed {
    logic       delay_mode;
    logic [6:0] payload;
  } wss_slot_t;

  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } wss_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } wss_av_rsp_t;

  // playback request to the waveform engine
  typedef struct packed {
    logic       start;
    logic [6:0] index;
  } wss_play_t;

  typedef enum logic [1:0] {
    WSS_IDLE,
    WSS_FETCH,
    WSS_PLAY,
    WSS_WAIT
  } wss_state_t;
endpackage

/* File: rtl/wss_delay_timer.sv */
/*
  counts a number of delay steps, each of step_cycles clocks, then pulses done.
  assumes load is a one-cycle pulse on the same clock and is not repeated while busy.
*/
`timescale 1ns/100ps
`include "wss_defs.svh"
module wss_delay_timer #(
  parameter int STEP_CYCLES = `WSS_STEP_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       load,
  input  wire logic [6:0] steps,
  output logic            done
);
  import wss_pkg::*;

  typedef struct packed {
    logic [6:0]  steps_left;
    logic [31:0] cyc;
    logic        busy;
    logic        done;
  } wss_tmr_t;

  wss_tmr_t s_q;
  wss_tmr_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (load) begin
      s_d.busy       = 1'b1;
      s_d.steps_left = steps;
      s_d.cyc        = 32'h0;
    end else if (s_q.busy) begin
      if (s_q.cyc == 32'(STEP_CYCLES - 1)) begin
        s_d.cyc        = 32'h0;
        s_d.steps_left = s_q.steps_left - 7'h01;
        if (s_q.steps_left == 7'h01) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.cyc = s_q.cyc + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
endmodule

/* File: rtl/wss_sequencer.sv */
/*
  eight-slot waveform playback sequencer with an avalon-mm register slave.
  assumes a waveform engine on the same clock that takes play.start and reports
  play_done as a one-cycle pulse when the waveform ends.
*/
// Notes on behaviour
// - mode bit one makes the payload an idle wait with no waveform
// - wait lasts payload times ten milliseconds before the next slot
// - mode bit zero makes the payload a library waveform index
// - start bit begins playback at the first slot
// - after a slot finishes, the next slot plays if its payload is non-zero
// - sequence ends at a zero payload or after all eight slots
// - zero payload stops the sequencer instead of playing
// - mode bit and payload of each slot are read-write and reset to zero
`timescale 1ns/100ps
`include "wss_defs.svh"
module wss_sequencer #(
  parameter int STEP_CYCLES = `WSS_STEP_CYCLES
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire wss_pkg::wss_av_req_t av_req,
  output wss_pkg::wss_av_rsp_t      av_rsp,
  output wss_pkg::wss_play_t        play,
  input  wire logic                 play_done,
  output logic                      busy
);
  import wss_pkg::*;

  typedef struct packed {
    wss_slot_t [`WSS_SLOT_COUNT-1:0] slot;
    wss_state_t                      state;
    logic [2:0]                      pos;
    logic                            go;
    wss_av_rsp_t                     rsp;
    logic                            acked;
    wss_play_t                       play;
    logic                            tmr_load;
    logic [6:0]                      tmr_steps;
    logic                            busy;
  } wss_seq_t;

  wss_seq_t s_q;
  wss_seq_t s_d;
  logic     tmr_done;

  function automatic logic [7:0] word_index(input logic [9:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic in_slots(input logic [7:0] idx);
    in_slots = (idx >= `WSS_IDX_SLOT_FIRST) && (idx <= `WSS_IDX_SLOT_LAST);
  endfunction

  wss_delay_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .load    (s_q.tmr_load),
    .steps   (s_q.tmr_steps),
    .done    (tmr_done)
  );

  always_comb begin
    logic [7:0] idx;
    logic [2:0] sidx;
    logic       req;
    wss_slot_t  cur;
    idx  = word_index(av_req.address);
    sidx = 3'(idx - `WSS_IDX_SLOT_FIRST);
    req  = av_req.read | av_req.write;
    cur  = s_q.slot[s_q.pos];

    s_d                 = s_q;
    s_d.play.start      = 1'b0;
    s_d.tmr_load        = 1'b0;
    s_d.go              = 1'b0;
    s_d.rsp.waitrequest = 1'b1;
    s_d.acked           = 1'b0;

    // one wait cycle then the answer; acked blocks a second answer on the same request
    if (req && !s_q.acked && s_q.rsp.waitrequest) begin
      s_d.rsp.waitrequest = 1'b0;
      s_d.acked           = 1'b1;
      s_d.rsp.readdata    = 32'h0;
      if (in_slots(idx)) begin
        s_d.rsp.readdata[7:0] = s_q.slot[sidx];
        if (av_req.write) begin
          s_d.slot[sidx] = av_req.writedata[7:0];
        end
      end else if (idx == `WSS_IDX_START) begin
        s_d.rsp.readdata[`WSS_START_BIT] = s_q.busy;
        if (av_req.write && av_req.writedata[`WSS_START_BIT]) begin
          s_d.go = 1'b1;
        end
      end else if (idx == `WSS_IDX_STATUS) begin
        s_d.rsp.readdata[`WSS_STAT_BUSY_BIT]                     = s_q.busy;
        s_d.rsp.readdata[`WSS_STAT_POS_LSB +: 3]                 = s_q.pos;
      end
    end else if (s_q.acked) begin
      s_d.rsp.readdata = s_q.rsp.readdata;
    end

    unique case (s_q.state)
      WSS_IDLE: begin
        s_d.busy = 1'b0;
        if (s_q.go) begin
          s_d.pos   = 3'h0;
          s_d.state = WSS_FETCH;
          s_d.busy  = 1'b1;
        end
      end
      WSS_FETCH: begin
        if (cur.payload == 7'h00) begin
          s_d.state = WSS_IDLE;
          s_d.busy  = 1'b0;
        end else if (cur.delay_mode) begin
          s_d.tmr_load  = 1'b1;
          s_d.tmr_steps = cur.payload;
          s_d.state     = WSS_WAIT;
        end else begin
          s_d.play.start = 1'b1;
          s_d.play.index = cur.payload;
          s_d.state      = WSS_PLAY;
        end
      end
      WSS_PLAY, WSS_WAIT: begin
        // slot position stays put until the engine or timer reports the end
        if ((s_q.state == WSS_PLAY && play_done) || (s_q.state == WSS_WAIT && tmr_done)) begin
          if (s_q.pos == 3'(`WSS_SLOT_COUNT - 1)) begin
            s_d.state = WSS_IDLE;
            s_d.busy  = 1'b0;
          end else begin
            s_d.pos   = s_q.pos + 3'h1;
            s_d.state = WSS_FETCH;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q                 <= '0;
      s_q.state           <= WSS_IDLE;
      s_q.rsp.waitrequest <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign av_rsp = s_q.rsp;
  assign play   = s_q.play;
  assign busy   = s_q.busy;
endmodule

/* File: test/wss_seq_sva.sv */
/* port checker of the sequencer.
   assumes it is bound onto wss_sequencer. */
`timescale 1ns/100ps
module wss_seq_sva #(
  parameter int STEP_CYCLES = 10
) (
  input wire logic                 ref_clk,
  input wire logic                 reset_n,
  input wire wss_pkg::wss_av_req_t av_req,
  input wire wss_pkg::wss_av_rsp_t av_rsp,
  input wire wss_pkg::wss_play_t   play,
  input wire logic                 play_done,
  input wire logic                 busy
);
  import wss_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_ack_next: assert property ($rose(av_req.read | av_req.write) |=> !av_rsp.waitrequest)
    else $error("no answer after request");
  a_ack_once: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("answer longer than one cycle");
  a_start_pulse: assert property (play.start |=> !play.start)
    else $error("start longer than one cycle");
  a_start_busy: assert property (play.start |-> busy)
    else $error("play outside a sequence");
  a_idle_quiet: assert property (!busy |-> !play.start)
    else $error("play while idle");
  a_index_held: assert property (!play.start |-> $stable(play.index))
    else $error("index moved without start");
  a_play_hold: assert property (play.start ##1 !play_done [*4] |-> !play.start)
    else $error("advance during waveform");
  a_go_busy: assert property (av_req.write && !av_rsp.waitrequest && av_req.address == 10'h030
    && av_req.writedata[0] |-> ##[1:3] busy)
    else $error("start did not begin");
endmodule
bind wss_sequencer wss_seq_sva #(.STEP_CYCLES(STEP_CYCLES)) wss_seq_sva_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .av_req(av_req), .av_rsp(av_rsp),
  .play(play), .play_done(play_done), .busy(busy));

/* File: test/test_waveform_sequence_slots.sv */
/* bench of the sequence slots: registers and playback.
   assumes the sequencer with a 10-clock delay step. */
`timescale 1ns/100ps
module test_waveform_sequence_slots;
  import wss_pkg::*;
  logic        ref_clk;
  logic        reset_n;
  wss_av_req_t req;
  wss_av_rsp_t rsp;
  wss_play_t   play;
  logic        play_done;
  logic        busy;
  logic [31:0] rd;
  logic [7:0]  sl [8];
  logic [6:0]  ex [8];
  int          errors;
  int          n_tests;
  int          cyc;

  wss_sequencer #(.STEP_CYCLES(10)) wss_sequencer_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .av_req(req), .av_rsp(rsp),
    .play(play), .play_done(play_done), .busy(busy));

  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      test_done;
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // holds the request until waitrequest is seen low
  task bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
    @(posedge ref_clk);
    req <= '{{ix, 2'b00}, !w, w, wd};
    do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
    rd = rsp.readdata;
    req <= '0;
  endtask

  task regs;
    bus(0, 8'h13, 0);
    chk("slot5 reset", 0, rd);
    bus(0, 8'h14, 0);
    chk("slot6 reset", 0, rd);
    bus(1, 8'h13, 32'hff);
    bus(1, 8'h14, 32'h2a);
    bus(0, 8'h13, 0);
    chk("slot5", 32'hff, rd);
    bus(0, 8'h14, 0);
    chk("slot6", 32'h2a, rd);
    bus(1, 8'h40, 32'h55);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, rd);
  endtask

  // the bench acts as waveform engine: done three cycles after each start
  task run(input int n, input int g);
    int t;
    for (int i = 0; i < 8; i++) bus(1, 8'(8'h0f + i), sl[i]);
    bus(1, 8'h0c, 1);
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge ref_clk);
        t++;
      end while (play.start !== 1'b1 && t < 300);
      chk("index", ex[k], play.index);
      if (k == 1) chk("gap", 1, t >= g && t <= g + 10);
      repeat (3) @(posedge ref_clk);
      play_done <= 1;
      @(posedge ref_clk);
      play_done <= 0;
    end
    t = 0;
    repeat (30) begin
      @(posedge ref_clk);
      if (play.start === 1'b1) t++;
    end
    chk("extra plays", 0, t);
    chk("busy", 0, busy);
  endtask

  task test_done;
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    reset_n = 0;
    req = '0;
    play_done = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1;
    regs;
    sl = '{8'h01, 8'h82, 8'h03, 8'h00, 8'h04, 8'h05, 8'h06, 8'h07};
    ex = '{7'h01, 7'h03, 0, 0, 0, 0, 0, 0};
    run(2, 20);
    for (int i = 0; i < 8; i++) begin
      sl[i] = 8'h70 + 8'(i);
      ex[i] = 7'h70 + 7'(i);
    end
    run(8, 0);
    test_done;
  end
endmodule
